// ===== src/rxbac_consts.svh
// Summary of operation
// - Bits after a collision stored as zero unless kept.
// - First-bit field picks first stored bit position.
// - Bits past bit 7 continue at next byte.
// - Zero first-bit field means byte-oriented reception.
// - Collision raises integrity error when so configured.
// - Final-valid-bits counts last byte bits, zero full.
// - Final-valid-bits cleared at start, loaded at end.
// - Position-valid set only for representable recorded collisions.
// - Seven-bit field holds first collision, data bits.
// - Positions recorded only within first eight bytes.
// - Positions zero-based, 0x3f is sixty-fourth bit.
// - First-bit offset is added into reported position.
// - Collision flag set, except collisions inside end-of-frame.
// - Integrity flag keeps reception going, cleared at start.
`ifndef RXBAC_CONSTS_SVH
`define RXBAC_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define RXBAC_IDX_BIT_CTRL  8'h0c
`define RXBAC_IDX_COLL_POS  8'h0d
`define RXBAC_IDX_FLAGS     8'h20
`define RXBAC_IDX_IRQ_STAT  8'h21
`define RXBAC_IDX_IRQ_MASK  8'h22

// Fields of rx_bit_control.
`define RXBAC_KEEP_BIT      7
`define RXBAC_ALIGN_MSB     6
`define RXBAC_ALIGN_LSB     4
`define RXBAC_COLLISION_AS_INTEGRITY_ERROR_BIT    3
`define RXBAC_LAST_MSB      2
`define RXBAC_LAST_LSB      0
`define RXBAC_CTRL_RST      8'h00

// Collision position limits.
`define RXBAC_LAST_POS      6'h3f
`define RXBAC_BYTE_TOP      3'h7

// Interrupt event positions.
`define RXBAC_EV_FRAME      0
`define RXBAC_EV_COLL       1
`define RXBAC_EV_INTEG      2
`define RXBAC_NUM_EV        3

`endif

// ===== src/rxbac_pkg.sv
package rxbac_pkg;

  // Receive phase of the block.
  typedef enum logic [0:0] {
    RXBAC_IDLE = 1'b0,
    RXBAC_RECV = 1'b1
  } rxbac_phase_t;

  // State of the bit packer.
  typedef struct packed {
    logic [2:0] pos;       // Next stored bit position.
    logic [7:0] data;      // Byte being assembled.
    logic       dirty;     // Current byte holds at least one bit.
    logic       out_valid; // Byte strobe.
    logic [7:0] out_data;  // Completed byte.
  } rxbac_pack_st_t;

  // State of the top block.
  typedef struct packed {
    rxbac_phase_t phase;
    logic [7:0]   ctrl;       // rx_bit_control.
    logic [2:0]   frame_align;// First-bit position caught at frame start.
    logic         coll_seen;  // A collision happened in this frame.
    logic [5:0]   abs;        // Stored bit index of the next bit.
    logic         over;       // Index ran past the eighth byte.
    logic         coll_valid;
    logic [6:0]   coll_pos;
    logic         integ;
    logic         collision_detected_flag;
    logic [2:0]   irq_stat;
    logic [2:0]   irq_mask;
    logic [31:0]  prdata;
    logic         slverr;
  } rxbac_top_st_t;

endpackage

// ===== src/rxbac_bit_packer.sv
`timescale 1ns/1ps
`include "rxbac_consts.svh"

// Places received bits into bytes, starting at a chosen bit position.
module rxbac_bit_packer (
  // Clock and reset.
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  // Frame control.
  input  wire logic       i_start,
  input  wire logic [2:0] i_align,
  input  wire logic       i_end,
  // Bit stream.
  input  wire logic       i_bit_valid,
  input  wire logic       i_bit,
  // Byte output.
  output logic            o_byte_valid,
  output logic [7:0]      o_byte_data,
  output logic [2:0]      o_fill
);

  rxbac_pkg::rxbac_pack_st_t q, d;

  // Next-state logic for the packer.
  always_comb begin
    logic [7:0] nd;
    nd = q.data;
    d = q;
    d.out_valid = 1'b0;
    if (i_start) begin
      d.pos   = i_align;
      d.data  = 8'h00;
      d.dirty = 1'b0;
    end else if (i_bit_valid) begin
      nd[q.pos] = i_bit;
      if (q.pos == `RXBAC_BYTE_TOP) begin
        // A full byte leaves; the next bit lands at bit 0 of a fresh byte.
        d.out_valid = 1'b1;
        d.out_data  = nd;
        d.data      = 8'h00;
        d.dirty     = 1'b0;
        d.pos       = 3'h0;
      end else begin
        d.data  = nd;
        d.dirty = 1'b1;
        d.pos   = q.pos + 3'h1;
      end
    end else if (i_end && q.dirty) begin
      // A partial last byte is flushed at the end of the frame.
      d.out_valid = 1'b1;
      d.out_data  = q.data;
      d.data      = 8'h00;
      d.dirty     = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_byte_valid = q.out_valid;
  assign o_byte_data  = q.out_data;
  assign o_fill       = q.pos;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  a_start_first_pos: assert property (i_start |=> o_fill == $past(i_align))
    else $error("first bit position not taken from align field");
  a_wrap_next_byte: assert property (i_bit_valid && !i_start && o_fill == 3'h7 |=> o_byte_valid && o_fill == 3'h0)
    else $error("bit past bit seven did not start a new byte");

endmodule // rxbac_bit_packer

// ===== src/rxbac_top.sv
`timescale 1ns/1ps
`include "rxbac_consts.svh"

// Receive bit framing and collision position recorder with an APB slave.
// The receive decoder hands over one data bit per strobe. Each bit is placed into
// the byte being assembled, starting at the first-bit position that software chose,
// and completed bytes leave on a one-cycle strobe.
// The first collision of a frame is remembered as a stored bit index, so software
// can resolve it during anticollision without tracking the alignment itself.
// Positions beyond the eighth stored byte are not representable and are reported
// as invalid rather than wrapped, which would point at the wrong bit.
// Register reads are captured in the setup cycle, so a read shows the state one
// cycle before the access edge; this keeps the read path free of long decode logic.
module rxbac_top #(
  parameter int ADDR_W = 12 // APB address width.
) (
  // Clock and reset.
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Bit stream from the receive decoder.
  input  wire logic        i_rx_start,
  input  wire logic        i_rx_bit_valid,
  input  wire logic        i_rx_bit,
  input  wire logic        i_rx_coll,
  input  wire logic        i_rx_eof_coll,
  input  wire logic        i_rx_integ_err,
  input  wire logic        i_rx_end,
  // Stored bytes.
  output logic             o_byte_valid,
  output logic [7:0]       o_byte_data,
  // Flags and interrupt.
  output logic             o_integrity_error,
  output logic             o_collision_detected,
  output logic             o_irq
);

  // The decode needs room for the highest register byte address.
  // A narrower bus would alias the flag and interrupt registers onto others,
  // so elaboration stops instead of building a block that decodes wrongly.
  if (ADDR_W < 10) begin : g_addr_chk
    $error("rxbac_top: ADDR_W must be at least 10");
  end

  // All state lives in one packed struct: q is the register and d its next value.
  // Keeping every field in one process makes it plain which update wins when the
  // bus side and the receive side touch the same field in one cycle.
  rxbac_pkg::rxbac_top_st_t q, d;

  // Helper nets shared by the bus decode, the receive path and the assertions.
  logic [2:0] fill;       // Packer's next bit position.
  logic       recv;       // Reception in progress.
  logic       rx_bit;     // Bit accepted this cycle.
  logic       pack_bit;   // Bit value after collision masking.
  logic       first_coll; // First collision of this frame.
  logic       setup;      // APB setup cycle.
  logic       wr_acc;     // APB write access edge.
  logic [2:0] ev;         // Interrupt events this cycle.

  // Compares the bus address with a register index.
  // The full address is compared, so a byte address that is not a multiple of four
  // never matches and ends in an error response instead of touching a register.
  function automatic logic hit(input logic [7:0] idx);
    hit = (i_paddr == ADDR_W'({idx, 2'b00}));
  endfunction

  // A frame start overrides every other stream input of the same cycle, so a bit that
  // arrives together with a start never lands in the frame that is being closed.
  assign recv       = (q.phase == rxbac_pkg::RXBAC_RECV) && !i_rx_start;
  assign rx_bit     = recv && i_rx_bit_valid;
  assign first_coll = rx_bit && i_rx_coll && !q.coll_seen;
  // Once a collision is seen the rest of the frame is forced to zero unless the keep bit is set.
  assign pack_bit   = i_rx_bit && !(q.coll_seen && !q.ctrl[`RXBAC_KEEP_BIT]);
  assign setup      = i_psel && !i_penable;
  assign wr_acc     = i_psel && i_penable && i_pwrite;

  // Byte assembly lives in its own module.
  // The packer takes the first-bit position straight from the control register at
  // the start strobe; a later write to that field only affects the next frame.
  rxbac_bit_packer u_pack (
    .i_sys_clk    (i_sys_clk),
    .i_rst_b      (i_rst_b),
    .i_start      (i_rx_start),
    .i_align      (q.ctrl[`RXBAC_ALIGN_MSB:`RXBAC_ALIGN_LSB]),
    .i_end        (recv && i_rx_end),
    .i_bit_valid  (rx_bit),
    .i_bit        (pack_bit),
    .o_byte_valid (o_byte_valid),
    .o_byte_data  (o_byte_data),
    .o_fill       (fill)
  );

  // Next-state logic: bus side first, so receive updates win.
  // The order matters for the final-valid-bits field: a software write in the cycle
  // that closes a frame is overwritten by the count that hardware loads.
  always_comb begin
    d = q;
    ev = 3'h0;

    // Read data is caught in the setup cycle and shown in the access cycle.
    // Reads have no side effects, so a master may repeat a read without losing status.
    if (setup) begin
      d.slverr = 1'b0;
      d.prdata = 32'h0000_0000;
      if (hit(`RXBAC_IDX_BIT_CTRL)) begin
        d.prdata[7:0] = q.ctrl;
      end else if (hit(`RXBAC_IDX_COLL_POS)) begin
        d.prdata[7:0] = {q.coll_valid, q.coll_pos};
      end else if (hit(`RXBAC_IDX_FLAGS)) begin
        d.prdata[2:0] = {recv, q.collision_detected_flag, q.integ};
      end else if (hit(`RXBAC_IDX_IRQ_STAT)) begin
        d.prdata[2:0] = q.irq_stat;
      end else if (hit(`RXBAC_IDX_IRQ_MASK)) begin
        d.prdata[2:0] = q.irq_mask;
      end else begin
        // Unmapped or misaligned addresses answer with an error.
        d.slverr = 1'b1;
      end
    end

    // Register writes take effect at the access edge.
    // Writes to read-only or unmapped addresses match no branch and change nothing.
    if (wr_acc) begin
      if (hit(`RXBAC_IDX_BIT_CTRL)) begin
        d.ctrl = i_pwdata[7:0];
      end else if (hit(`RXBAC_IDX_IRQ_MASK)) begin
        d.irq_mask = i_pwdata[2:0];
      end else if (hit(`RXBAC_IDX_IRQ_STAT)) begin
        d.irq_stat = q.irq_stat & ~i_pwdata[2:0];
      end
    end

    // Frame start wipes every per-frame result.
    // Without this a frame that sees no collision would still show the position of
    // the previous one, and software would resolve a collision that never happened.
    if (i_rx_start) begin
      d.phase       = rxbac_pkg::RXBAC_RECV;
      d.frame_align = q.ctrl[`RXBAC_ALIGN_MSB:`RXBAC_ALIGN_LSB];
      d.abs         = {3'h0, q.ctrl[`RXBAC_ALIGN_MSB:`RXBAC_ALIGN_LSB]};
      d.over        = 1'b0;
      d.coll_seen   = 1'b0;
      d.coll_valid  = 1'b0;
      d.coll_pos    = 7'h00;
      d.integ       = 1'b0;
      d.collision_detected_flag     = 1'b0;
      d.ctrl[`RXBAC_LAST_MSB:`RXBAC_LAST_LSB] = 3'h0;
    end else if (recv) begin
      if (rx_bit) begin
        if (first_coll) begin
          d.coll_seen = 1'b1;
          d.collision_detected_flag   = 1'b1;
          ev[`RXBAC_EV_COLL] = 1'b1;
          // Positions beyond the eighth byte cannot be shown.
          if (!q.over) begin
            d.coll_valid = 1'b1;
            d.coll_pos   = {1'b0, q.abs};
          end
        end
        // A collision may count as an integrity error; reception goes on.
        if (i_rx_coll && q.ctrl[`RXBAC_COLLISION_AS_INTEGRITY_ERROR_BIT]) begin
          d.integ = 1'b1;
          ev[`RXBAC_EV_INTEG] = !q.integ;
        end
        // The index stops at the last representable bit; the over flag then marks
        // every later bit, so the six-bit index never wraps back into range.
        if (q.abs == `RXBAC_LAST_POS) begin
          d.over = 1'b1;
        end else if (!q.over) begin
          d.abs = q.abs + 6'h01;
        end
      end
      // A parity or checksum failure marks the frame but lets reception go on.
      // Collisions inside the end-of-frame symbol are not reported: that strobe is
      // deliberately kept out of the flag logic.
      if (i_rx_integ_err) begin
        d.integ = 1'b1;
        ev[`RXBAC_EV_INTEG] = !q.integ;
      end
      if (i_rx_end) begin
        d.phase = rxbac_pkg::RXBAC_IDLE;
        ev[`RXBAC_EV_FRAME] = 1'b1;
        // Bit-oriented frames report how many bits the last byte holds.
        if (q.frame_align != 3'h0 || fill != 3'h0) begin
          d.ctrl[`RXBAC_LAST_MSB:`RXBAC_LAST_LSB] = fill;
        end
      end
    end

    // Events set after the clear, so a new event is never lost.
    d.irq_stat = d.irq_stat | ev;
  end

  // State register.
  // Reset is synchronous, so every field returns to its idle value at the first
  // clock edge that sees the reset input low.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      q       <= '0;
      q.ctrl  <= `RXBAC_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // Zero wait states: the access cycle always completes.
  // Ready is combinational from the bus controls; a master never waits, and the
  // error response is only shown while ready is high, as the bus requires.
  // The interrupt is a level: it stays high until software clears the status bit
  // or masks it, so a missed edge in the interrupt controller is harmless.
  assign o_pready             = i_psel && i_penable;
  assign o_prdata             = q.prdata;
  assign o_pslverr            = q.slverr && o_pready;
  assign o_integrity_error    = q.integ;
  assign o_collision_detected = q.collision_detected_flag;
  assign o_irq                = |(q.irq_stat & q.irq_mask);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // A first collision right after a frame start.
  sequence s_start_then_coll;
    i_rx_start ##1 (i_rx_bit_valid && i_rx_coll && !i_rx_start);
  endsequence

  // A data bit that collides while a frame is open.
  sequence s_coll_bit;
    rx_bit && i_rx_coll;
  endsequence

  // The end strobe of a bit-oriented frame, with no bit in the same cycle.
  sequence s_bit_close;
    recv && i_rx_end && !i_rx_bit_valid && (q.frame_align != 3'h0 || fill != 3'h0);
  endsequence

  // The end strobe of a byte-oriented frame of whole bytes, with no bus write beside it.
  sequence s_byte_close;
    recv && i_rx_end && !i_rx_bit_valid && q.frame_align == 3'h0 && fill == 3'h0 && !wr_acc;
  endsequence

  // A parity or checksum failure reported inside an open frame.
  sequence s_integ_fault;
    recv && i_rx_integ_err;
  endsequence

  // A frame start leaves no stale position behind.
  a_start_clears_pos: assert property (i_rx_start |=> !q.coll_valid && q.coll_pos == 7'h00)
    else $error("collision position not cleared at frame start");
  // A frame start clears the final bit count and the integrity flag.
  a_start_clears_last: assert property (i_rx_start |=> q.ctrl[2:0] == 3'h0 && !q.integ)
    else $error("final bits or integrity flag not cleared at start");
  // A collision in the very first bit reports the first-bit position itself.
  a_coll_pos_offset: assert property (s_start_then_coll |=> q.coll_valid && q.coll_pos == {4'h0, $past(q.ctrl[6:4], 2)})
    else $error("collision position does not include first-bit offset");
  // A valid position never points past the eighth byte.
  a_coll_pos_range: assert property (q.coll_valid |-> q.coll_pos <= 7'h3f)
    else $error("collision position outside eight bytes");
  // With the option set, a collision also counts as an integrity error.
  a_coll_integ_err: assert property (rx_bit && i_rx_coll && q.ctrl[3] |=> o_integrity_error)
    else $error("collision did not raise integrity error");
  // Every data collision shows on the collision flag.
  a_coll_detected: assert property (rx_bit && i_rx_coll |=> o_collision_detected)
    else $error("collision flag not set");
  // A collision inside the end-of-frame symbol leaves the flag clear.
  a_eof_coll_quiet: assert property (i_rx_eof_coll && !rx_bit && !i_rx_start && !q.collision_detected_flag |=> !q.collision_detected_flag)
    else $error("end-of-frame collision set the collision flag");
  // Bits after a collision are stored as zero unless they are kept.
  a_zero_after_coll: assert property (q.coll_seen && !q.ctrl[7] && rx_bit |-> !pack_bit)
    else $error("bit after collision was not zeroed");
  // A frame end in the same cycle as a status clear is not lost.
  a_set_wins_clear: assert property (ev[0] && wr_acc && hit(`RXBAC_IDX_IRQ_STAT) && i_pwdata[0] |=> q.irq_stat[0])
    else $error("frame event lost against status clear");
  // Hardware loads the final bit count when a bit-oriented frame closes.
  a_last_bits_load: assert property (s_bit_close |=> q.ctrl[`RXBAC_LAST_MSB:`RXBAC_LAST_LSB] == $past(fill))
    else $error("final valid bits not loaded at frame end");
  // A byte-oriented frame of whole bytes leaves the cleared count alone.
  a_byte_mode_keep: assert property (s_byte_close |=> $stable(q.ctrl[`RXBAC_LAST_MSB:`RXBAC_LAST_LSB]))
    else $error("byte-oriented frame changed final valid bits");
  // A parity fault raises the integrity flag one cycle later.
  a_integ_fault_set: assert property (s_integ_fault |=> o_integrity_error)
    else $error("integrity fault did not raise the flag");
  // The fault does not stop reception: the frame stays open until its end strobe.
  a_integ_keeps_rx: assert property (s_integ_fault ##0 !i_rx_end |=> q.phase == rxbac_pkg::RXBAC_RECV)
    else $error("integrity fault stopped reception");
  // The integrity flag holds until the next frame start clears it.
  a_integ_sticky: assert property (o_integrity_error && !i_rx_start |=> o_integrity_error)
    else $error("integrity flag dropped before a new frame");
  // The collision flag holds until the next frame start clears it.
  a_collision_detected_flag_sticky: assert property (o_collision_detected && !i_rx_start |=> o_collision_detected)
    else $error("collision flag dropped before a new frame");
  // A frame start clears the collision flag of the previous frame.
  a_start_clears_det: assert property (i_rx_start |=> !o_collision_detected)
    else $error("collision flag not cleared at frame start");
  // A collision past the eighth byte is flagged but never positioned.
  a_beyond_invalid: assert property (first_coll && q.over |=> !q.coll_valid)
    else $error("collision beyond eight bytes marked valid");
  // The first collision inside the range records a valid position.
  a_first_coll_valid: assert property (s_coll_bit ##0 (!q.coll_seen && !q.over) |=> q.coll_valid)
    else $error("first collision in range not marked valid");

endmodule // rxbac_top

// ===== dv/rxbac_card_model.sv
`timescale 1ns/1ps

// Card side of the RF link, as it arrives from the receive decoder.
module rxbac_card_model (
  // Clock.
  input  wire logic i_sys_clk,
  // Decoded stream.
  output logic      o_start,
  output logic      o_bit_valid,
  output logic      o_bit,
  output logic      o_coll,
  output logic      o_eof_coll,
  output logic      o_integ_err,
  output logic      o_end
);
  // All strobes rest low before the first frame.
  initial begin
    {o_start, o_bit_valid, o_bit, o_coll, o_eof_coll, o_integ_err, o_end} = 7'h00;
  end

  // Sends one frame of back to back bits, then the optional faults, then the end pulse.
  // Outside bit cycles the data line shows the inverse of the last bit, so stale data never matches.
  task automatic frame(input logic [79:0] data, input int nbits, input int coll_at,
                       input logic eof, input logic integ);
    @(posedge i_sys_clk);
    o_start <= 1'b1;
    @(posedge i_sys_clk);
    o_start <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_bit_valid <= 1'b1;
      o_bit       <= data[i];
      o_coll      <= (i == coll_at);
      @(posedge i_sys_clk);
    end
    o_bit_valid <= 1'b0;
    o_coll      <= 1'b0;
    o_bit       <= ~o_bit;
    o_integ_err <= integ;
    o_eof_coll  <= eof;
    @(posedge i_sys_clk);
    o_integ_err <= 1'b0;
    o_eof_coll  <= 1'b0;
    o_end       <= 1'b1;
    @(posedge i_sys_clk);
    o_end       <= 1'b0;
  endtask
endmodule // rxbac_card_model

// ===== dv/tb.sv
`timescale 1ns/1ps

// Self-checking bench: APB master, card model and a byte monitor.
module tb;
  logic        sys_clk, rst_b, psel, penable, pwrite;   // Clock, reset and APB controls.
  logic [11:0] paddr;                                   // APB byte address.
  logic [31:0] pwdata, prdata;                          // APB data.
  logic        pready, pslverr, byte_valid, int_err, coll_det, irq;
  logic [7:0]  byte_data;                               // Stored byte.
  logic        st, bv, bt, cl, ec, ie, en;              // Stream from the card model.
  logic [7:0]  got_q[$];                                // Bytes seen in the current frame.
  int          failures, check_count;

  rxbac_top dut (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_rx_start(st), .i_rx_bit_valid(bv), .i_rx_bit(bt), .i_rx_coll(cl),
    .i_rx_eof_coll(ec), .i_rx_integ_err(ie), .i_rx_end(en), .o_byte_valid(byte_valid),
    .o_byte_data(byte_data), .o_integrity_error(int_err), .o_collision_detected(coll_det), .o_irq(irq));

  rxbac_card_model card (.i_sys_clk(sys_clk), .o_start(st), .o_bit_valid(bv), .o_bit(bt), .o_coll(cl),
    .o_eof_coll(ec), .o_integ_err(ie), .o_end(en));

  // The 100 ns system clock.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Every byte strobe is a one-cycle pulse, so it is caught at each edge.
  always @(posedge sys_clk) begin
    if (byte_valid === 1'b1) got_q.push_back(byte_data);
  end

  task report_and_stop;
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Compares a register or byte value.
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a single flag output.
  task chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk_word(r, exp);
    chk_bit(e, 1'b0);
  endtask

  // Runs one frame and checks bytes, final bit count, collision position and flags.
  // The expected stream is rebuilt bit by bit, so wrap and zeroing faults show as wrong bytes.
  task automatic run_frame(input logic [7:0] ctrl, input logic [79:0] data, input int nbits,
                           input int coll_at, input logic eof, input logic pulse_integ);
    logic [7:0] cur;
    logic [7:0] exp_q[$];
    int         pos;
    int         cp;
    pos = ctrl[6:4];
    cur = 8'h00;
    cp  = pos + coll_at;
    wr(12'h030, {24'h0, ctrl});
    got_q.delete();
    card.frame(data, nbits, coll_at, eof, pulse_integ);
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      cur[pos] = data[i] & (ctrl[7] || coll_at < 0 || i <= coll_at);
      pos++;
      if (pos == 8) begin
        exp_q.push_back(cur);
        cur = 8'h00;
        pos = 0;
      end
    end
    if (pos != 0) exp_q.push_back(cur);
    chk_word(32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[k]) chk_word({24'h0, got_q[k]}, {24'h0, exp_q[k]});
    rd_chk(12'h030, {24'h0, ctrl[7:3], 3'(pos)});
    rd_chk(12'h034, (coll_at >= 0 && cp <= 63) ? (32'h80 | 32'(cp)) : 32'h0);
    chk_bit(coll_det, coll_at >= 0);
    chk_bit(int_err, pulse_integ | (ctrl[3] & (coll_at >= 0)));
  endtask

  // Reset values, a write to the read-only position register and an unmapped address.
  task automatic s_reset;
    logic [31:0] r;
    logic        e;
    rd_chk(12'h030, 32'h0);
    rd_chk(12'h034, 32'h0);
    rd_chk(12'h080, 32'h0);
    wr(12'h034, 32'hff);
    rd_chk(12'h034, 32'h0);
    apb(1'b0, 12'h03c, 32'h0, r, e);
    chk_bit(e, 1'b1);
    chk_word(r, 32'h0);
  endtask

  // Position 7 with kept bits: a collision in the first bit reports position 7,
  // and the kept second bit lands at bit 0 of the next byte.
  task s_align7;
    run_frame(8'hf0, 80'h3, 2, 0, 1'b0, 1'b0);
  endtask

  // Collision in the fourth bit at position 4, zeroing, integrity error and an unmasked interrupt.
  task s_coll_irq;
    wr(12'h088, 32'h2);
    run_frame(8'h48, 80'hfff, 12, 3, 1'b0, 1'b0);
    chk_bit(irq, 1'b1);
    rd_chk(12'h084, 32'h7);
    wr(12'h084, 32'h7);
    rd_chk(12'h084, 32'h0);
    chk_bit(irq, 1'b0);
  endtask

  // Last representable position, kept bits, end-of-frame collision and a parity fault.
  task s_last_pos;
    run_frame(8'h80, 80'h0123456789abcdef, 64, 63, 1'b1, 1'b1);
  endtask

  // Collision in the ninth byte is flagged but not positioned; the interrupt stays masked.
  task s_beyond;
    wr(12'h088, 32'h0);
    wr(12'h084, 32'h7);
    run_frame(8'h00, 80'h5a0123456789abcdef, 72, 64, 1'b0, 1'b0);
    rd_chk(12'h084, 32'h3);
    chk_bit(irq, 1'b0);
  endtask

  // A clean frame after faulty ones must report no stale results,
  // and a collision inside its end-of-frame symbol stays unreported.
  task s_clean;
    run_frame(8'h10, 80'h1ff, 9, -1, 1'b1, 1'b0);
  endtask

  // Main sequence.
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    failures = 0;
    check_count = 0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    s_reset();
    s_align7();
    s_coll_irq();
    s_last_pos();
    s_beyond();
    s_clean();
    report_and_stop();
  end
endmodule // tb
